// ### verilog/osm_pkg.sv
package osm_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OSM_CTRL_OFS = 8'h00;
	localparam logic [7:0] OSM_TRIM_OFS = 8'h04;
	localparam logic [7:0] OSM_STAT_OFS = 8'h08;

	// Field positions inside the control register.
	localparam int OSM_CHOICE_LSB = 0;
	localparam int OSM_PRIM_BIT = 3;
	localparam int OSM_IFC_LSB = 4;

	// Field positions inside the status register.
	localparam int OSM_ST_LSB = 0;
	localparam int OSM_CNT_LSB = 16;

	// Values after reset.
	localparam logic [1:0] OSM_CHOICE_RST = 2'h0;
	localparam logic [2:0] OSM_IFC_RST = 3'h3;
	localparam logic [5:0] OSM_TRIM_RST = 6'h00;

	// System clock choice codes; any code with bit 1 set is internal.
	localparam logic [1:0] OSM_CHOICE_PRIMARY = 2'h0;
	localparam logic [1:0] OSM_CHOICE_SECONDARY = 2'h1;

	// Start-up oscillation count and timing figures.
	localparam int OSM_STARTUP_COUNT = 1024;
	localparam int OSM_CLK_MHZ = 50;
	localparam int OSM_MULT_EXTRA_US = 2000;
	localparam int OSM_MULT_EXTRA_CYC = OSM_MULT_EXTRA_US * OSM_CLK_MHZ;
	localparam int OSM_SWITCH_NS = 1000;
	localparam int OSM_SWITCH_CYC = (OSM_SWITCH_NS * OSM_CLK_MHZ + 999) / 1000;
	localparam int OSM_WARM_NS = 5000;
	localparam int OSM_WARM_CYC = (OSM_WARM_NS * OSM_CLK_MHZ + 999) / 1000;

	// Nominal internal oscillator rates in hertz.
	localparam int OSM_FAST_HZ = 16000000;
	localparam int OSM_MID_HZ = 500000;
	localparam int OSM_SLOW_HZ = 31250;

	// Primary clock source modes as strapped by configuration pins.
	typedef enum logic [2:0] {
		MODE_DRIVEN = 3'h0,
		MODE_XTAL_LOW = 3'h1,
		MODE_XTAL_MID = 3'h2,
		MODE_XTAL_HIGH_MED = 3'h3,
		MODE_XTAL_HIGH_TOP = 3'h4,
		MODE_RC = 3'h5,
		MODE_RC_PIN = 3'h6,
		MODE_INTERNAL = 3'h7
	} osm_mode_t;

	// Amplifier gain settings.
	typedef enum logic [2:0] {
		GAIN_OFF = 3'h0,
		GAIN_LOW = 3'h1,
		GAIN_MID = 3'h2,
		GAIN_HIGH = 3'h3,
		GAIN_TOP = 3'h4
	} osm_gain_t;

	// Internal oscillator in use.
	typedef enum logic [1:0] {
		IOSC_FAST = 2'h1,
		IOSC_SLOW = 2'h2
	} osm_iosc_t;

	// Start-up sequencer states.
	typedef enum logic [4:0] {
		ST_POWER_UP = 5'h01,
		ST_COUNT = 5'h02,
		ST_EXTRA = 5'h04,
		ST_SETTLE = 5'h08,
		ST_RUN = 5'h10
	} osm_state_t;

endpackage : osm_pkg

// ### verilog/osm_source_modes.sv
`timescale 1ns/1ns
// Function
// - Crystal modes count 1024 input oscillations first
// - Counting starts after power-up delay, or wake
// - Execution held while the counter runs
// - Source change inserts a stabilisation delay
// - Multiplier start waits 1024 cycles plus 2 ms
// - Internal oscillators start after warm-up delay at boot or wake; a choice change uses the switch delay
// - Driven mode clocks from input, frees output
// - Driven mode skips the start-up count
// - Static logic halts and resumes with clock
// - Crystal modes use low, mid, high gain
// - High-gain mode offers medium and top drive
// - RC mode drives output at input over four
// - RC pin mode frees the output pin
// - Three internal oscillators at nominal rates
// - Trim adjusts fast and mid, not slow
// - Clock choice field selects external or internal
// - Internal speed chosen by three-bit field
// - Choice 00 primary, 01 secondary, 1x internal
// - Every reset clears the clock choice field
// - Internal frequency defaults to 1 MHz
module osm_source_modes
	import osm_pkg::*;
#(
	parameter int MULT_CYC = OSM_MULT_EXTRA_CYC,
	parameter int WARM_CYC = OSM_WARM_CYC,
	parameter int SWITCH_CYC = OSM_SWITCH_CYC
)
(
	// Clock and reset.
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// APB slave.
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Configuration and power sequencing pins.
	input wire logic [2:0] primary_mode_i,
	input wire logic multiplier_en_i,
	input wire logic power_up_done_i,
	input wire logic wake_i,
	// Oscillator pins.
	input wire logic crystal_in_pin_i,
	output logic crystal_out_pin_o,
	output logic crystal_out_pin_oe_o,
	output logic crystal_out_gpio_o,
	// Clock tree controls.
	output logic [2:0] amp_gain_o,
	output logic [1:0] sys_src_o,
	output logic [2:0] int_freq_o,
	output logic [1:0] int_osc_sel_o,
	output logic [5:0] fast_trim_o,
	output logic [5:0] mid_trim_o,
	// Core control.
	output logic exec_run_o,
	output logic pc_hold_o
);

	// Tells whether a clock choice code selects the internal block.
	function automatic logic is_internal(input logic [1:0] code);
		is_internal = code[1];
	endfunction : is_internal

	// Tells whether a mode runs a crystal amplifier.
	function automatic logic is_crystal(input logic [2:0] m);
		is_crystal = (m == MODE_XTAL_LOW) || (m == MODE_XTAL_MID) ||
			(m == MODE_XTAL_HIGH_MED) || (m == MODE_XTAL_HIGH_TOP);
	endfunction : is_crystal

	logic [6:0] sync1;
	logic [6:0] sync2;
	logic osc_prev;
	logic wake_prev;
	logic osc_rise;
	logic wake_rise;
	logic [2:0] mode_s;
	logic mult_s;
	logic power_up_s;
	logic [1:0] clk_choice;
	logic [2:0] ifc;
	logic [5:0] trim;
	logic warm;
	logic [1:0] quarter;
	logic [10:0] osc_cnt;
	logic [16:0] timer;
	osm_state_t state;
	osm_state_t next_state;
	osm_state_t boot_state;
	logic boot_warm;
	logic wr_fire;
	logic rd_fire;
	logic choice_change;
	logic [16:0] settle_last;

	// Two-stage synchronisers for every pin input.
	always_ff @(posedge ref_clk_i)
	begin
		sync1 <= {crystal_in_pin_i, wake_i, power_up_done_i, multiplier_en_i,
			primary_mode_i};
		sync2 <= sync1;
	end

	// Edge history taken from the second stage only.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			osc_prev <= 1'b0;
			wake_prev <= 1'b0;
		end
		else
		begin
			osc_prev <= sync2[6];
			wake_prev <= sync2[5];
		end
	end

	// Decoded synchronised inputs.
	assign osc_rise = sync2[6] & ~osc_prev;
	assign wake_rise = sync2[5] & ~wake_prev;
	assign power_up_s = sync2[4];
	assign mult_s = sync2[3];
	assign mode_s = sync2[2:0];

	// APB request qualifiers; one wait state before every answer.
	assign rd_fire = psel_i & penable_i & ~pready_o;
	assign wr_fire = psel_i & penable_i & pwrite_i & pready_o;
	assign choice_change = wr_fire && (paddr_i == OSM_CTRL_OFS) &&
		(pwdata_i[OSM_CHOICE_LSB +: 2] != clk_choice);

	// APB handshake and read data.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end
		else
		begin
			pready_o <= rd_fire;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
			if (rd_fire)
			begin
				if (paddr_i == OSM_CTRL_OFS)
				begin
					prdata_o[OSM_CHOICE_LSB +: 2] <= clk_choice;
					prdata_o[OSM_PRIM_BIT] <=
						(clk_choice == OSM_CHOICE_PRIMARY) &&
						(state == ST_RUN);
					prdata_o[OSM_IFC_LSB +: 3] <= ifc;
				end
				else if (paddr_i == OSM_TRIM_OFS)
					prdata_o[5:0] <= trim;
				else if (paddr_i == OSM_STAT_OFS)
				begin
					prdata_o[OSM_ST_LSB +: 5] <= state;
					prdata_o[OSM_CNT_LSB +: 11] <= osc_cnt;
				end
				else
					pslverr_o <= 1'b1;
			end
		end
	end

	// Control register: clock choice and internal frequency.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			clk_choice <= OSM_CHOICE_RST;
			ifc <= OSM_IFC_RST;
		end
		else if (wr_fire && (paddr_i == OSM_CTRL_OFS))
		begin
			clk_choice <= pwdata_i[OSM_CHOICE_LSB +: 2];
			ifc <= pwdata_i[OSM_IFC_LSB +: 3];
		end
	end

	// Trim register feeds the fast and mid oscillators only.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			trim <= OSM_TRIM_RST;
		else if (wr_fire && (paddr_i == OSM_TRIM_OFS))
			trim <= pwdata_i[5:0];
	end

	// Where a fresh start goes once power-up delay is met or on wake.
	always_comb
	begin
		boot_warm = 1'b0;
		if (!is_internal(clk_choice) && is_crystal(mode_s))
			boot_state = ST_COUNT;
		else if (is_internal(clk_choice) || (mode_s == MODE_INTERNAL))
		begin
			boot_state = ST_SETTLE;
			boot_warm = 1'b1;
		end
		else
			boot_state = ST_RUN;
	end

	assign settle_last = warm ? 17'(WARM_CYC - 1) : 17'(SWITCH_CYC - 1);

	// Start-up sequencer transitions.
	always_comb
	begin
		next_state = state;
		case (state)
			ST_POWER_UP:
				if (power_up_s)
					next_state = boot_state;
			ST_COUNT:
				// Counts only real input edges, so a stopped clock just waits.
				if (osc_rise && (osc_cnt == 11'(OSM_STARTUP_COUNT - 1)))
					next_state = mult_s ? ST_EXTRA : ST_RUN;
			ST_EXTRA:
				if (timer == 17'(MULT_CYC - 1))
					next_state = ST_RUN;
			ST_SETTLE:
				if (timer == settle_last)
					next_state = ST_RUN;
			ST_RUN:
				if (choice_change)
					next_state = ST_SETTLE;
				else if (wake_rise)
					next_state = boot_state;
			default:
				next_state = ST_POWER_UP;
		endcase
	end

	// State register and the settle length chosen on entry.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state <= ST_POWER_UP;
			warm <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (next_state == ST_SETTLE && state != ST_SETTLE)
				warm <= (state == ST_RUN && choice_change) ? 1'b0 : boot_warm;
		end
	end

	// Oscillation counter and delay timer, cleared on every state entry.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i || next_state != state)
		begin
			osc_cnt <= 11'h0;
			timer <= 17'h0;
		end
		else
		begin
			if (state == ST_COUNT && osc_rise)
				osc_cnt <= osc_cnt + 11'h1;
			if (state == ST_EXTRA || state == ST_SETTLE)
				timer <= timer + 17'h1;
		end
	end

	// Execution gate follows the sequencer.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			exec_run_o <= 1'b0;
			pc_hold_o <= 1'b1;
		end
		else
		begin
			exec_run_o <= (next_state == ST_RUN);
			pc_hold_o <= (next_state != ST_RUN);
		end
	end

	// Quarter-rate divider of the input clock for RC mode.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			quarter <= 2'h0;
		else if (osc_rise)
			quarter <= quarter + 2'h1;
	end

	// Output pin usage and amplifier gain per mode.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			crystal_out_pin_o <= 1'b0;
			crystal_out_pin_oe_o <= 1'b0;
			crystal_out_gpio_o <= 1'b0;
			amp_gain_o <= GAIN_OFF;
		end
		else
		begin
			crystal_out_pin_o <= (mode_s == MODE_RC) & quarter[1];
			crystal_out_pin_oe_o <= (mode_s == MODE_RC);
			crystal_out_gpio_o <= (mode_s == MODE_DRIVEN) ||
				(mode_s == MODE_RC_PIN) || (mode_s == MODE_INTERNAL);
			case (mode_s)
				MODE_XTAL_LOW: amp_gain_o <= GAIN_LOW;
				MODE_XTAL_MID: amp_gain_o <= GAIN_MID;
				MODE_XTAL_HIGH_MED: amp_gain_o <= GAIN_HIGH;
				MODE_XTAL_HIGH_TOP: amp_gain_o <= GAIN_TOP;
				default: amp_gain_o <= GAIN_OFF;
			endcase
		end
	end

	// Clock tree selection and oscillator trim outputs.
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			sys_src_o <= OSM_CHOICE_RST;
			int_freq_o <= OSM_IFC_RST;
			int_osc_sel_o <= IOSC_FAST;
			fast_trim_o <= OSM_TRIM_RST;
			mid_trim_o <= OSM_TRIM_RST;
		end
		else
		begin
			sys_src_o <= clk_choice;
			int_freq_o <= ifc;
			int_osc_sel_o <= (ifc == 3'h0) ? IOSC_SLOW : IOSC_FAST;
			fast_trim_o <= trim;
			mid_trim_o <= trim;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_count_len;
		(state == ST_COUNT && next_state != ST_COUNT) |->
			(osc_cnt == 11'(OSM_STARTUP_COUNT - 1)) && osc_rise;
	endproperty
	a_count_len: assert property (p_count_len)
		else $error("start-up count ended early");

	property p_wake_count;
		(state == ST_RUN && wake_rise && !choice_change &&
			!is_internal(clk_choice) && is_crystal(mode_s)) |=>
			(state == ST_COUNT);
	endproperty
	a_wake_count: assert property (p_wake_count)
		else $error("wake did not restart counting");

	property p_hold;
		(state != ST_RUN) |-> (!exec_run_o && pc_hold_o);
	endproperty
	a_hold: assert property (p_hold)
		else $error("execution ran while not stable");

	property p_switch;
		(state == ST_RUN && choice_change) |=> (state == ST_SETTLE) ##1
			(state == ST_SETTLE && !exec_run_o);
	endproperty
	a_switch: assert property (p_switch)
		else $error("source change skipped settle delay");

	property p_mult;
		(state == ST_EXTRA && next_state == ST_RUN) |->
			(timer == 17'(MULT_CYC - 1));
	endproperty
	a_mult: assert property (p_mult)
		else $error("multiplier delay wrong length");

	property p_driven;
		(state == ST_POWER_UP && power_up_s && mode_s == MODE_DRIVEN &&
			!is_internal(clk_choice)) |=> (state == ST_RUN) && exec_run_o;
	endproperty
	a_driven: assert property (p_driven)
		else $error("driven mode was delayed");

	property p_rc_out;
		(mode_s == MODE_RC && $past(mode_s) == MODE_RC &&
			$changed(crystal_out_pin_o)) |-> $past(osc_rise, 2) &&
			($past(quarter) == 2'h0 || $past(quarter) == 2'h2);
	endproperty
	a_rc_out: assert property (p_rc_out)
		else $error("rc output not input over four");

	property p_reset_vals;
		disable iff (1'b0)
		rst_i |=> (clk_choice == OSM_CHOICE_RST) && (ifc == OSM_IFC_RST);
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");

	property p_top_gain;
		(mode_s == MODE_XTAL_HIGH_TOP) |=> (amp_gain_o == GAIN_TOP);
	endproperty
	a_top_gain: assert property (p_top_gain)
		else $error("top drive gain not applied");

endmodule : osm_source_modes

// ### verification/osm_xtal_model.sv
`timescale 1ns/1ns
// Crystal or clock generator on the oscillator input pin.
module osm_xtal_model
#(
	parameter int HALF_NS = 30
)
(
	// Bench control.
	input wire logic run_i,
	// Oscillator pin.
	output logic osc_o
);

	// Toggles while running and parks low once stopped, as a halted source.
	initial
	begin
		osc_o = 1'b0;
		// Keeps every pin edge clear of the bench clock edges.
		#(HALF_NS / 6);
		forever
		begin
			#(HALF_NS);
			if (run_i || osc_o)
				osc_o = ~osc_o;
		end
	end

endmodule : osm_xtal_model

// ### verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import osm_pkg::*;
	typedef struct {
		logic [2:0] m;
		logic [2:0] g;
		logic [1:0] io;
		int lo;
		int hi;
	} osm_row_t;
	localparam int MULT = 20;
	localparam int WARM = 4;
	localparam int SW = 3;
	localparam logic [31:0] MASK = 32'hffff_fff7;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [2:0] mode = 3'h4;
	logic mult = 1'b0;
	logic power_up = 1'b0;
	logic wake = 1'b0;
	logic xrun = 1'b1;
	logic xin, pready, pslverr, xout, xoe, xgpio, run, hold;
	logic [31:0] prdata;
	logic [2:0] gain, ifreq;
	logic [1:0] src, osel;
	logic [5:0] ftrim, mtrim;
	int miscompares = 0;
	int n_checks = 0;
	int xe = 0;
	int oc = 0;
	int cyc, dx, t0;
	logic [1:0] pick [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	// Strap, gain, gpio and enable, start-up cycle bounds.
	osm_row_t rows [8] = '{
		'{3'h0, 3'h0, 2'b10, 2, 6},
		'{3'h1, 3'h1, 2'b00, 3068, 3100},
		'{3'h2, 3'h2, 2'b00, 3068, 3100},
		'{3'h3, 3'h3, 2'b00, 3068, 3100},
		'{3'h4, 3'h4, 2'b00, 3068, 3100},
		'{3'h5, 3'h0, 2'b01, 2, 6},
		'{3'h6, 3'h0, 2'b10, 2, 6},
		'{3'h7, 3'h0, 2'b10, 6, 14}
	};

	// Design with shortened delays.
	osm_source_modes #(.MULT_CYC(MULT), .WARM_CYC(WARM), .SWITCH_CYC(SW))
	i_osm_source_modes (
		.ref_clk_i(ref_clk), .rst_i(rst), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .primary_mode_i(mode),
		.multiplier_en_i(mult), .power_up_done_i(power_up), .wake_i(wake),
		.crystal_in_pin_i(xin), .crystal_out_pin_o(xout),
		.crystal_out_pin_oe_o(xoe), .crystal_out_gpio_o(xgpio),
		.amp_gain_o(gain), .sys_src_o(src), .int_freq_o(ifreq),
		.int_osc_sel_o(osel), .fast_trim_o(ftrim), .mid_trim_o(mtrim),
		.exec_run_o(run), .pc_hold_o(hold));

	// Oscillator source at about 16.7 MHz.
	osm_xtal_model i_osm_xtal_model (.run_i(xrun), .osc_o(xin));

	// Clock of 20 ns period.
	always #10 ref_clk = ~ref_clk;

	// Rising edges on the oscillator pins.
	always @(posedge xin) xe++;
	always @(posedge xout) oc++;

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic span(input int v, input int lo, input int hi);
		chk(v >= lo && v <= hi, 32'h1);
	endtask : span

	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [31:0] exp, input logic err);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		chk(pslverr, err);
		if (!w)
			chk(prdata & MASK, exp);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	task automatic do_reset(input logic [2:0] m);
		rst <= 1'b1;
		power_up <= 1'b0;
		mode <= m;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask : do_reset

	// Kind 0 releases power-up, 1 wakes, 2 waits out a switch.
	task automatic boot(input int kind);
		int e0;
		logic lo;
		e0 = xe;
		cyc = 0;
		lo = (kind == 0);
		if (kind == 0)
			power_up <= 1'b1;
		if (kind == 1)
			wake <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			cyc++;
			if (run === 1'b0)
				lo = 1'b1;
			if (cyc == 100)
				chk({run, hold}, 32'h1);
			if (kind == 1 && cyc == 1500)
				xrun <= 1'b0;
			if (kind == 1 && cyc == 1800)
			begin
				chk(run, 32'h0);
				xrun <= 1'b1;
			end
		end
		while (!(lo && run === 1'b1) && cyc < 9000);
		dx = xe - e0;
		wake <= 1'b0;
	endtask : boot

	// Main sequence.
	initial
	begin
		foreach (rows[i])
		begin
			do_reset(rows[i].m);
			chk({gain, xgpio, xoe, src, ifreq, run, hold},
				{rows[i].g, rows[i].io, 7'h0d});
			boot(0);
			span(cyc, rows[i].lo, rows[i].hi);
			if (rows[i].lo > 100)
				span(dx, 1024, 1028);
			if (rows[i].m == 3'h4)
				t0 = cyc;
			if (rows[i].m == 3'h5)
			begin
				dx = xe;
				cyc = oc;
				wait (xe == dx + 40);
				span(oc - cyc, 9, 11);
				@(posedge ref_clk);
			end
			$display("mode %0d done", rows[i].m);
		end
		mult <= 1'b1;
		do_reset(3'h4);
		boot(0);
		span(cyc - t0, MULT - 3, MULT + 3);
		mult <= 1'b0;
		repeat (4) @(posedge ref_clk);
		boot(1);
		span(dx, 1024, 1028);
		$display("multiplier and wake done");
		apb(OSM_CTRL_OFS, 1'b0, 32'h0, 32'h30, 1'b0);
		apb(OSM_TRIM_OFS, 1'b1, 32'h25, 32'h0, 1'b0);
		apb(OSM_TRIM_OFS, 1'b0, 32'h0, 32'h25, 1'b0);
		chk({ftrim, mtrim}, {20'h0, 6'h25, 6'h25});
		apb(8'h0c, 1'b0, 32'h0, 32'h0, 1'b1);
		apb(8'h0c, 1'b1, 32'hffff_ffff, 32'h0, 1'b1);
		apb(OSM_STAT_OFS, 1'b1, 32'hffff_ffff, 32'h0, 1'b0);
		foreach (pick[k])
		begin
			apb(OSM_CTRL_OFS, 1'b1, {26'h0, pick[k], 2'h0, pick[k]},
				32'h0, 1'b0);
			boot(2);
			span(cyc, SW - 1, 20);
			chk({src, ifreq, osel}, {pick[k], 1'b0, pick[k],
				((pick[k] == 2'h0) ? 2'h2 : 2'h1)});
			apb(OSM_CTRL_OFS, 1'b0, 32'h0,
				{26'h0, pick[k], 2'h0, pick[k]}, 1'b0);
		end
		$display("registers done");
		do_reset(3'h4);
		apb(OSM_CTRL_OFS, 1'b0, 32'h0, 32'h30, 1'b0);
		chk({ftrim, run, hold}, 32'h1);
		$display("reset done");
		complete_run();
	end

	// Watchdog against a hung handshake or start-up.
	initial
	begin
		#1000000;
		miscompares++;
		complete_run();
	end

endmodule : tb_top
